// ### core/pep_core.sv
// strap capture and 100 Mb/s coding paths between the reduced MAC interface and the line
`default_nettype none
// Functional notes
// R1 - at reset release, address strap high gives address 00011b, low gives 00000b
// R2 - address zero is broadcast until software sets bit 9 of control word 16h
// R3 - address bits 4 to 2 are always zero; strap only sets low bits
// R4 - wake strap captured at reset release into bit 15 of word 16h
// R5 - speed strap high: negotiation on, 100 Mb/s; low: negotiation off, 10 Mb/s
// R6 - speed strap loads word 0h bits 12 and 13 and the advertised speed set
// R7 - strap pins are inputs only during reset, then drive their normal output
// R8 - address strap shares carrier/valid pin, wake strap shares receive error pin
// R9 - control words writable by management, interrupt raised on status change
// R10 - clock source mode defaults by variant: crystal or 50 MHz reference input
// R11 - transmit dibits are serialised into a line bit stream
// R12 - transmit order: 4B/5B encode, scramble, then NRZI
// R13 - receive recovers bit timing from NRZI edges and converts back to NRZ; here line bits are taken one per clock with no timing recovery
// R14 - receive order: descramble, 4B/5B decode, then dibits to the MAC
// R15 - MAC data is two bits wide each way, one dibit per reference clock; here two dibits per five clocks, on tx_take_out and rx_valid_out
// R16 - MAC drives 00 (idle) or 01 (low-power idle) while transmit enable is low
// R17 - scrambler and descrambler only act at 100 Mb/s, bypassed at 10 Mb/s
// R18 - standard 100BASE-TX code groups and scrambler; two dibits per nibble
// R19 - straps captured once at reset release; later only software writes change them
module pep_core #(
   parameter bit REF_CLK_INPUT_MODE = 1'b0
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic mgmt_address_strap_in,
   input wire logic wake_event_output_strap_in,
   input wire logic negotiation_speed_strap_in,
   output logic crs_dv_pin_out,
   output logic crs_dv_oe_n_out,
   output logic rx_err_pin_out,
   output logic rx_err_oe_n_out,
   output logic led_pin_out,
   output logic led_oe_n_out,
   input wire logic reg0_wr_in,
   input wire logic reg16_wr_in,
   input wire logic [15:0] wr_data_in,
   input wire logic irq_clr_in,
   output logic [4:0] mgmt_addr_out,
   output logic addr0_broadcast_out,
   output logic wake_event_enable_out,
   output logic neg_enable_out,
   output logic speed_100_out,
   output logic [3:0] adv_cap_out,
   output logic ref_clk_input_mode_out,
   output logic irq_out,
   input wire logic tx_en_in,
   input wire logic [1:0] txd_in,
   output logic tx_take_out,
   output logic line_tx_out,
   input wire logic line_rx_in,
   output logic [1:0] rxd_out,
   output logic rx_valid_out
);
   import pep_pkg::*;

   logic rst_q;
   logic release_edge;
   assign release_edge = rst_q && !rst_in;

   always_ff @(posedge clk_in) begin
      rst_q <= rst_in;
   end

   // straps: sampled in the first cycle after release, never again (see R19)
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         mgmt_addr_out <= PEP_ADDR_STRAP_LO;
         wake_event_enable_out <= 1'b0;
         neg_enable_out <= 1'b1;
         speed_100_out <= 1'b1;
         adv_cap_out <= PEP_ADV_ALL;
      end else if (release_edge) begin
         mgmt_addr_out <= mgmt_address_strap_in ? PEP_ADDR_STRAP_HI : PEP_ADDR_STRAP_LO; // see R1, see R3
         wake_event_enable_out <= wake_event_output_strap_in; // see R4
         neg_enable_out <= negotiation_speed_strap_in; // see R5, see R6
         speed_100_out <= negotiation_speed_strap_in; // see R5, see R6
         adv_cap_out <= negotiation_speed_strap_in ? PEP_ADV_ALL : PEP_ADV_10_ONLY; // see R6
      end else begin
         if (reg0_wr_in) begin
            neg_enable_out <= wr_data_in[PEP_REG0_NEG_BIT]; // see R9
            speed_100_out <= wr_data_in[PEP_REG0_SPEED_BIT];
         end
         if (reg16_wr_in) begin
            wake_event_enable_out <= wr_data_in[PEP_REG16_WAKE_BIT]; // see R9
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         addr0_broadcast_out <= 1'b1;
      end else if (reg16_wr_in) begin
         addr0_broadcast_out <= !wr_data_in[PEP_REG16_UNIQUE_BIT]; // see R2
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ref_clk_input_mode_out <= 1'b0;
      end else begin
         ref_clk_input_mode_out <= REF_CLK_INPUT_MODE; // see R10
      end
   end

   // shared pins let go while reset holds so the straps can be read
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         crs_dv_oe_n_out <= 1'b1; // see R7
         rx_err_oe_n_out <= 1'b1;
         led_oe_n_out <= 1'b1;
      end else begin
         crs_dv_oe_n_out <= 1'b0; // see R7, see R8
         rx_err_oe_n_out <= 1'b0;
         led_oe_n_out <= 1'b0;
      end
   end

   // ---------------- transmit ----------------
   logic [2:0] tx_slot;
   logic [2:0] next_tx_slot;
   logic [1:0] tx_lo;
   logic tx_frame;
   logic [3:0] tx_nib;
   logic [4:0] tx_sym;
   logic [10:0] tx_lfsr;
   logic tx_key;
   logic tx_nrz;
   pep_tx_state_e tx_state;

   assign next_tx_slot = (tx_slot == PEP_SLOT_LAST) ? 3'h0 : 3'(tx_slot + 3'h1);
   assign tx_nib = {txd_in, tx_lo}; // see R18
   assign tx_key = tx_lfsr[10] ^ tx_lfsr[8];
   assign tx_nrz = speed_100_out ? (tx_sym[4] ^ tx_key) : tx_sym[4]; // see R12, see R17

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         tx_slot <= PEP_SLOT_LAST;
         tx_take_out <= 1'b0;
      end else begin
         tx_slot <= next_tx_slot;
         tx_take_out <= (next_tx_slot == PEP_SLOT_LO) || (next_tx_slot == PEP_SLOT_HI); // see R15
      end
   end

   // low dibit and enable caught first, high dibit joins at the load
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         tx_lo <= 2'h0;
         tx_frame <= 1'b0;
      end else if (tx_slot == PEP_SLOT_LO) begin
         tx_lo <= txd_in;
         tx_frame <= tx_en_in; // see R16
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         tx_state <= PEP_TX_IDLE;
         tx_sym <= PEP_SYM_I;
      end else if (tx_slot == PEP_SLOT_HI) begin
         case (tx_state)
            PEP_TX_IDLE: begin
               tx_sym <= tx_frame ? PEP_SYM_J : PEP_SYM_I; // see R12, see R18
               tx_state <= tx_frame ? PEP_TX_K : PEP_TX_IDLE;
            end
            PEP_TX_K: begin
               tx_sym <= PEP_SYM_K;
               tx_state <= PEP_TX_DATA;
            end
            PEP_TX_DATA: begin
               tx_sym <= tx_frame ? pep_enc(tx_nib) : PEP_SYM_T;
               tx_state <= tx_frame ? PEP_TX_DATA : PEP_TX_R;
            end
            default: begin
               tx_sym <= PEP_SYM_R;
               tx_state <= PEP_TX_IDLE;
            end
         endcase
      end else begin
         tx_sym <= {tx_sym[3:0], tx_sym[4]}; // see R11
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         tx_lfsr <= PEP_LFSR_SEED;
         line_tx_out <= 1'b0;
      end else begin
         tx_lfsr <= {tx_lfsr[9:0], tx_key};
         line_tx_out <= line_tx_out ^ tx_nrz; // see R12
      end
   end

   // ---------------- receive ----------------
   // line bits arrive one per clock already aligned; edge timing is taken from the
   // previous line level, so no oversampling is needed at this rate
   logic rx_prev;
   logic rx_nrz;
   logic [10:0] rx_lfsr;
   logic rx_key;
   logic rx_plain;
   logic [5:0] rx_lock_cnt;
   logic rx_locked;
   logic rx_locked_q;
   logic [9:0] rx_sh;
   logic [9:0] next_rx_sh;
   logic rx_in_frame;
   logic [2:0] rx_slot;
   logic [4:0] rx_dec;
   logic [1:0] rx_hi;
   logic rx_hi_pend;

   assign rx_key = rx_lfsr[10] ^ rx_lfsr[8];
   assign rx_plain = speed_100_out ? (rx_nrz ^ rx_key) : rx_nrz; // see R14, see R17
   assign next_rx_sh = {rx_sh[8:0], rx_plain};
   assign rx_dec = pep_dec(next_rx_sh[4:0]); // see R14, see R18

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rx_prev <= 1'b0;
         rx_nrz <= 1'b0;
      end else begin
         rx_prev <= line_rx_in;
         rx_nrz <= line_rx_in ^ rx_prev; // see R13
      end
   end

   // self-synchronising: while unlocked, assume idle ones and load the key
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rx_lfsr <= PEP_LFSR_SEED;
         rx_lock_cnt <= 6'h00;
         rx_locked <= 1'b0;
      end else begin
         rx_lfsr <= {rx_lfsr[9:0], rx_locked ? rx_key : !rx_nrz}; // see R14
         if (!rx_locked) begin
            rx_lock_cnt <= rx_plain ? 6'(rx_lock_cnt + 6'h01) : 6'h00;
            rx_locked <= rx_plain && (rx_lock_cnt == PEP_LOCK_BITS);
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rx_sh <= 10'h000;
         rx_in_frame <= 1'b0;
         rx_slot <= 3'h0;
         rx_valid_out <= 1'b0;
         rxd_out <= 2'h0;
         rx_hi <= 2'h0;
         rx_hi_pend <= 1'b0;
         rx_err_pin_out <= 1'b0;
         crs_dv_pin_out <= 1'b0;
      end else begin
         rx_sh <= next_rx_sh;
         rx_valid_out <= 1'b0;
         rx_hi_pend <= 1'b0;
         rx_slot <= (rx_slot == PEP_SLOT_LAST) ? 3'h0 : 3'(rx_slot + 3'h1);
         if (rx_hi_pend) begin
            rxd_out <= rx_hi; // see R15
            rx_valid_out <= 1'b1;
         end
         if (!rx_in_frame) begin
            rx_err_pin_out <= 1'b0;
            if (rx_locked && next_rx_sh == {PEP_SYM_J, PEP_SYM_K}) begin
               rx_in_frame <= 1'b1;
               crs_dv_pin_out <= 1'b1; // see R8
               rx_slot <= 3'h0;
               rxd_out <= PEP_PREAMBLE_NIB[1:0];
               rx_hi <= PEP_PREAMBLE_NIB[3:2];
               rx_valid_out <= 1'b1;
               rx_hi_pend <= 1'b1;
            end
         end else if (rx_slot == PEP_SLOT_LAST) begin
            if (next_rx_sh[4:0] == PEP_SYM_T || next_rx_sh[4:0] == PEP_SYM_I) begin
               rx_in_frame <= 1'b0;
               crs_dv_pin_out <= 1'b0;
            end else begin
               rxd_out <= rx_dec[1:0]; // see R14
               rx_hi <= rx_dec[3:2];
               rx_valid_out <= 1'b1;
               rx_hi_pend <= 1'b1;
               rx_err_pin_out <= !rx_dec[4]; // see R8
            end
         end
      end
   end

   // status change: descrambler lock gained (only reset clears the lock); a new event beats the clear
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rx_locked_q <= 1'b0;
         irq_out <= 1'b0;
         led_pin_out <= 1'b1;
      end else begin
         rx_locked_q <= rx_locked;
         led_pin_out <= !rx_locked;
         if (rx_locked != rx_locked_q) begin
            irq_out <= 1'b1; // see R9
         end else if (irq_clr_in) begin
            irq_out <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ### inc/pep_pkg.sv
// constants, symbol tables and types shared by the fast ethernet coding core
`default_nettype none
package pep_pkg;
   // strap results
   localparam logic [4:0] PEP_ADDR_STRAP_HI = 5'h03;
   localparam logic [4:0] PEP_ADDR_STRAP_LO = 5'h00;
   localparam logic [3:0] PEP_ADV_ALL = 4'hF;
   localparam logic [3:0] PEP_ADV_10_ONLY = 4'h3;
   // control word bit positions
   localparam int PEP_REG0_NEG_BIT = 12;
   localparam int PEP_REG0_SPEED_BIT = 13;
   localparam int PEP_REG16_UNIQUE_BIT = 9;
   localparam int PEP_REG16_WAKE_BIT = 15;
   // code groups, sent leftmost bit first
   localparam logic [4:0] PEP_SYM_I = 5'h1F;
   localparam logic [4:0] PEP_SYM_J = 5'h18;
   localparam logic [4:0] PEP_SYM_K = 5'h11;
   localparam logic [4:0] PEP_SYM_T = 5'h0D;
   localparam logic [4:0] PEP_SYM_R = 5'h07;
   localparam logic [3:0] PEP_PREAMBLE_NIB = 4'h5;
   // bit slots per code group and slots where the two dibits are taken
   localparam logic [2:0] PEP_SLOT_LAST = 3'h4;
   localparam logic [2:0] PEP_SLOT_LO = 3'h0;
   localparam logic [2:0] PEP_SLOT_HI = 3'h2;
   // idle bits in a row before the descrambler counts as locked
   localparam logic [5:0] PEP_LOCK_BITS = 6'h3C;
   localparam logic [10:0] PEP_LFSR_SEED = 11'h7FF;

   typedef enum {PEP_TX_IDLE, PEP_TX_K, PEP_TX_DATA, PEP_TX_R} pep_tx_state_e;

   function automatic logic [4:0] pep_enc(input logic [3:0] nib);
      logic [4:0] s;
      s = PEP_SYM_I;
      case (nib)
         4'h0: s = 5'h1E;
         4'h1: s = 5'h09;
         4'h2: s = 5'h14;
         4'h3: s = 5'h15;
         4'h4: s = 5'h0A;
         4'h5: s = 5'h0B;
         4'h6: s = 5'h0E;
         4'h7: s = 5'h0F;
         4'h8: s = 5'h12;
         4'h9: s = 5'h13;
         4'hA: s = 5'h16;
         4'hB: s = 5'h17;
         4'hC: s = 5'h1A;
         4'hD: s = 5'h1B;
         4'hE: s = 5'h1C;
         default: s = 5'h1D;
      endcase
      return s;
   endfunction

   // returns {valid, nibble}
   function automatic logic [4:0] pep_dec(input logic [4:0] sym);
      logic [4:0] r;
      r = 5'h00;
      for (int i = 0; i < 16; i++) begin
         if (pep_enc(4'(i)) == sym) begin
            r = {1'b1, 4'(i)};
         end
      end
      return r;
   endfunction
endpackage
`default_nettype wire

// ### tb/pep_core_bench.sv
// bench for the strap and coding core, line looped back to itself
`default_nettype none
module pep_core_bench import pep_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_in = 0, rst_in = 1, reg0_wr_in = 0, reg16_wr_in = 0, irq_clr_in = 0, eee = 0, prev;
   logic mgmt_address_strap_in = 0, wake_event_output_strap_in = 0, negotiation_speed_strap_in = 1;
   logic [15:0] wr_data_in = 16'h0000;
   logic crs_dv_pin_out, crs_dv_oe_n_out, rx_err_pin_out, rx_err_oe_n_out, led_pin_out, led_oe_n_out;
   logic [4:0] mgmt_addr_out;
   logic [3:0] adv_cap_out;
   logic [1:0] txd_in, rxd_out;
   logic addr0_broadcast_out, wake_event_enable_out, neg_enable_out, speed_100_out, ref_clk_input_mode_out, irq_out;
   logic tx_en_in, tx_take_out, line_tx_out, rx_valid_out;
   logic [1:0] exp_q[$];
   int n_mismatch = 0, samples_checked = 0, tog;
   always #20 clk_in = ~clk_in;
   pep_core DUT (.line_rx_in(line_tx_out), .*);
   pep_mac mac (.clk_in(clk_in), .rst_in(rst_in), .take_in(tx_take_out), .eee_in(eee), .tx_en_out(tx_en_in),
      .txd_out(txd_in));
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_of_test();
      if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // J,K stands in for the first two nibbles and comes back as one preamble nibble
   task automatic frame(input int len);
      logic [3:0] nib;
      for (int i = 0; i < len; i++) begin
         nib = (i < 4) ? PEP_PREAMBLE_NIB : (i == 4) ? 4'hD : 4'($urandom);
         mac.tx_q.push_back(nib);
         if (i != 1) exp_q.push_back(nib[1:0]);
         if (i != 1) exp_q.push_back(nib[3:2]);
      end
      for (tog = 0; tog < 3000 && exp_q.size() > 0; tog++) @(negedge clk_in);
      if (exp_q.size() > 0) begin
         n_mismatch++;
         end_of_test();
      end
   endtask
   always @(posedge clk_in) begin
      if (!rst_in && rx_valid_out) begin
         if (exp_q.size() == 0) chk("rxd extra", 16'(rxd_out), 16'hFFFF);
         else chk("rxd", 16'(rxd_out), 16'(exp_q.pop_front()));
         chk("rx err", 16'(rx_err_pin_out), 16'h0000);
      end
   end
   initial begin
      void'($urandom(98000));
      for (int k = 0; k < 8; k++) begin
         {negotiation_speed_strap_in, wake_event_output_strap_in, mgmt_address_strap_in} = 3'(k);
         eee = k[1];
         rst_in = 1;
         repeat (10) @(negedge clk_in);
         chk("oe reset", 16'({crs_dv_oe_n_out, rx_err_oe_n_out, led_oe_n_out}), 16'h0007);
         rst_in = 0;
         @(negedge clk_in);
         // later pin levels must not leak into the latched set
         {negotiation_speed_strap_in, wake_event_output_strap_in, mgmt_address_strap_in} = ~3'(k);
         @(negedge clk_in);
         chk("addr", 16'(mgmt_addr_out), k[0] ? 16'h0003 : 16'h0000);
         chk("bcast", 16'(addr0_broadcast_out), 16'h0001);
         chk("wake", 16'(wake_event_enable_out), 16'(k[1]));
         chk("neg", 16'({neg_enable_out, speed_100_out, adv_cap_out}), k[2] ? 16'h003F : 16'h0003);
         chk("oe run", 16'({crs_dv_oe_n_out, rx_err_oe_n_out, led_oe_n_out}), 16'h0000);
         chk("clk mode", 16'(ref_clk_input_mode_out), 16'h0000);
         repeat (20) @(negedge clk_in);
         prev = line_tx_out;
         tog = 0;
         repeat (40) begin
            @(negedge clk_in);
            tog += int'(line_tx_out != prev);
            prev = line_tx_out;
         end
         chk("idle toggles", 16'(tog == 40), 16'(!k[2]));
         repeat (150) @(negedge clk_in);
         // descrambler lock by now: link shown on the pin and the interrupt raised
         chk("irq led", 16'({irq_out, led_pin_out}), 16'h0002);
         irq_clr_in = 1;
         @(negedge clk_in);
         irq_clr_in = 0;
         chk("irq clr", 16'(irq_out), 16'h0000);
         frame(12 + k);
         chk("addr held", 16'(mgmt_addr_out), k[0] ? 16'h0003 : 16'h0000);
      end
      wr_data_in = 16'($urandom) | 16'h0200;
      reg16_wr_in = 1;
      @(negedge clk_in);
      chk("bcast wr", 16'(addr0_broadcast_out), 16'h0000);
      chk("wake wr", 16'(wake_event_enable_out), 16'(wr_data_in[15]));
      reg16_wr_in = 0;
      reg0_wr_in = 1;
      wr_data_in = 16'($urandom);
      @(negedge clk_in);
      reg0_wr_in = 0;
      chk("reg0 wr", 16'({neg_enable_out, speed_100_out}), 16'({wr_data_in[12], wr_data_in[13]}));
      end_of_test();
   end
endmodule
`default_nettype wire

// ### tb/pep_core_monitor.sv
// port-level assertions for the strap and coding core
`default_nettype none
module pep_core_monitor import pep_pkg::*; #(
   parameter bit REF_CLK_INPUT_MODE = 1'b0
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic mgmt_address_strap_in,
   input wire logic wake_event_output_strap_in,
   input wire logic negotiation_speed_strap_in,
   input wire logic crs_dv_pin_out,
   input wire logic crs_dv_oe_n_out,
   input wire logic rx_err_oe_n_out,
   input wire logic led_oe_n_out,
   input wire logic reg0_wr_in,
   input wire logic reg16_wr_in,
   input wire logic [15:0] wr_data_in,
   input wire logic [4:0] mgmt_addr_out,
   input wire logic addr0_broadcast_out,
   input wire logic wake_event_enable_out,
   input wire logic neg_enable_out,
   input wire logic speed_100_out,
   input wire logic [3:0] adv_cap_out,
   input wire logic ref_clk_input_mode_out,
   input wire logic tx_take_out,
   input wire logic [1:0] rxd_out,
   input wire logic rx_valid_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   sequence rel_s; !rst_in && $past(rst_in); endsequence
   sequence slot_s; !tx_take_out ##1 tx_take_out; endsequence
   sequence pre_s; rxd_out == 2'h1 && rx_valid_out; endsequence
   oe_reset_a: assert property (disable iff (1'b0) rst_in |=> crs_dv_oe_n_out && rx_err_oe_n_out && led_oe_n_out)
      else $error("strap pin driven in reset");
   oe_run_a: assert property (!rst_in |=> !crs_dv_oe_n_out && !rx_err_oe_n_out && !led_oe_n_out)
      else $error("pin not driven after reset");
   addr_strap_a: assert property (rel_s |=> addr0_broadcast_out && mgmt_addr_out ==
      ($past(mgmt_address_strap_in) ? PEP_ADDR_STRAP_HI : PEP_ADDR_STRAP_LO)) else $error("address strap wrong");
   wake_strap_a: assert property (rel_s |=> wake_event_enable_out == $past(wake_event_output_strap_in))
      else $error("wake strap wrong");
   speed_strap_a: assert property (rel_s |=> neg_enable_out == $past(negotiation_speed_strap_in) &&
      speed_100_out == $past(negotiation_speed_strap_in) &&
      adv_cap_out == ($past(negotiation_speed_strap_in) ? PEP_ADV_ALL : PEP_ADV_10_ONLY)) else $error("speed strap wrong");
   cfg_hold_a: assert property (!rst_in && !$past(rst_in) && !reg0_wr_in && !reg16_wr_in |=>
      $stable({mgmt_addr_out, addr0_broadcast_out, wake_event_enable_out, neg_enable_out, speed_100_out, adv_cap_out}))
      else $error("configuration moved");
   reg16_write_a: assert property (reg16_wr_in |=> addr0_broadcast_out == !$past(wr_data_in[PEP_REG16_UNIQUE_BIT]) &&
      wake_event_enable_out == $past(wr_data_in[PEP_REG16_WAKE_BIT])) else $error("word 16h write wrong");
   reg0_write_a: assert property (reg0_wr_in |=> neg_enable_out == $past(wr_data_in[PEP_REG0_NEG_BIT]) &&
      speed_100_out == $past(wr_data_in[PEP_REG0_SPEED_BIT])) else $error("word 0h write wrong");
   clk_mode_a: assert property (!rst_in |=> ref_clk_input_mode_out == REF_CLK_INPUT_MODE)
      else $error("clock mode wrong");
   take_slot_a: assert property (tx_take_out |=> slot_s or (!tx_take_out ##1 slot_s))
      else $error("dibit slot spacing wrong");
   rx_start_a: assert property ($rose(crs_dv_pin_out) |-> pre_s ##1 pre_s)
      else $error("frame start dibits wrong");
endmodule
bind pep_core pep_core_monitor #(.REF_CLK_INPUT_MODE(REF_CLK_INPUT_MODE)) mon (.*);
`default_nettype wire

// ### tb/pep_mac.sv
// MAC transmit model feeding dibits on the core's take strobe
`default_nettype none
module pep_mac (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic take_in,
   input wire logic eee_in,
   output logic tx_en_out,
   output logic [1:0] txd_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] tx_q[$];
   logic [3:0] cur = 4'h0;
   logic hi = 1'b0;
   // half a cycle ahead of the sampling edge, held until the next take
   always @(negedge clk_in) begin
      if (rst_in) begin
         hi = 1'b0;
         tx_en_out = 1'b0;
         txd_out = 2'h0;
      end else if (take_in) begin
         if (!hi) begin
            tx_en_out = tx_q.size() > 0;
            if (tx_en_out) cur = tx_q.pop_front();
         end
         txd_out = !tx_en_out ? {1'b0, eee_in} : hi ? cur[3:2] : cur[1:0];
         hi = !hi;
      end
   end
endmodule
`default_nettype wire
